/* tc_scan_defines.vh */
`ifndef TC_SCAN_DEFINES_VH
`define TC_SCAN_DEFINES_VH

// register index = register number minus 40001
`define REG_SLAVE_ADDR 8'h00
`define REG_UART_SETUP 8'h01
`define REG_DELAYS 8'h02
`define REG_CHAN_ENABLE 8'h03
`define REG_CONV_RATE 8'h04
`define REG_LARGE_FILT 8'h05
`define REG_SMALL_FILT 8'h06
`define REG_TYPE_BASE 8'h07
`define REG_VERSION 8'h20
`define REG_CONV_STATUS 8'h2f
`define REG_DATA_BASE 8'h30

// field layouts
`define UART_BAUD_LSB 0
`define UART_BAUD_MSB 4
`define UART_PAR_LSB 5
`define UART_PAR_MSB 6
`define STATUS_CHAN_LSB 8
`define STATUS_CHAN_MSB 10

// reset values
`define RST_SLAVE_ADDR 8'h01
// baud code 5 in bits 4:0, parity code 3 (none, one stop) in 6:5
`define RST_UART_SETUP 16'h0065
`define RST_DELAYS 16'h0003
`define RST_CHAN_ENABLE 7'h7f
`define RST_CONV_RATE 16'h003c
`define RST_FILTER 16'h0000
`define RST_TYPE 3'h0
`define RST_DATA 16'h8000

// sensor type codes
`define TYPE_J 3'h0
`define TYPE_K 3'h1
`define TYPE_T 3'h2
`define TYPE_E 3'h3
`define TYPE_R 3'h4
`define TYPE_S 3'h5
`define TYPE_B 3'h6
`define TYPE_C 3'h7

// timing
`define CLK_MHZ 100
`define CONV_PER_SEC 25
`define CONV_PERIOD_US (1000000 / `CONV_PER_SEC)
`define CONV_PERIOD_CYCLES (`CONV_PERIOD_US * `CLK_MHZ)

`define NUM_CHAN 7
`endif

/* tc_scan_ctrl.v */
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "tc_scan_defines.vh"

module tc_scan_ctrl #(
	parameter CONV_PERIOD = `CONV_PERIOD_CYCLES,
	parameter [15:0] VERSION_CODE = 16'h0001
)(
	// clock and reset
	input wire core_clk,
	input wire rst_n,
	// register port
	input wire [7:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [15:0] reg_rdata,
	// shared converter
	output reg conv_start,
	output reg [2:0] conv_chan,
	output reg [2:0] conv_type,
	input wire conv_done,
	input wire [15:0] conv_result,
	// settings toward the serial engine and filters, and the busy status
	output wire [7:0] slave_addr,
	output wire [4:0] baud_sel,
	output wire [1:0] parity_sel,
	output wire [7:0] resp_delay_ms,
	output wire [7:0] query_delay_ms,
	output wire [15:0] conv_rate,
	output wire [15:0] large_filt,
	output wire [15:0] small_filt,
	output wire [6:0] chan_enable,
	output wire busy
);

	localparam S_IDLE = 1'b0;
	localparam S_CONV = 1'b1;

	// next enabled channel above cur, wrapping to the lowest
	function [2:0] next_chan;
		input [2:0] cur;
		input [6:0] en;
		integer i;
		reg [3:0] sum;
		reg found;
		begin
			next_chan = cur;
			found = 1'b0;
			for (i = 1; i <= `NUM_CHAN; i = i + 1)
			begin
				// four bits so cur + i cannot overflow before the wrap
				sum = {1'b0, cur} + i[3:0];
				if (sum >= 4'd7)
					sum = sum - 4'd7;
				if (!found && en[sum[2:0]])
				begin
					next_chan = sum[2:0];
					found = 1'b1;
				end
			end
		end
	endfunction

	// true when addr falls in a block of seven starting at base
	function in_chan_block;
		input [7:0] addr;
		input [7:0] base;
		begin
			in_chan_block = (addr >= base) && (addr < base + 8'd7);
		end
	endfunction

	reg [7:0] slave_addr_q;
	reg [15:0] uart_setup_q;
	reg [15:0] delays_q;
	reg [6:0] chan_en_q;
	reg [15:0] conv_rate_q;
	reg [15:0] large_filt_q;
	reg [15:0] small_filt_q;
	reg [2:0] type_q [0:6];
	reg [15:0] data_q [0:6];
	reg [7:0] conv_cnt_q;
	reg [2:0] last_chan_q;
	reg [2:0] cur_chan_q;
	reg state_q;
	reg [31:0] tick_cnt_q;
	reg tick_q;
	wire [2:0] wr_idx;
	wire [2:0] rd_idx;
	wire [2:0] seq_next;
	wire [7:0] wr_off;
	wire [7:0] rd_off;
	integer k;
	integer m;

	// offsets within a channel block; only the low bits index the arrays
	assign wr_off = reg_addr - `REG_TYPE_BASE;
	assign rd_off = reg_addr - `REG_DATA_BASE;
	assign wr_idx = wr_off[2:0];
	assign rd_idx = rd_off[2:0];

	// settings drive the neighbouring blocks straight from storage
	assign slave_addr = slave_addr_q;
	assign baud_sel = uart_setup_q[`UART_BAUD_MSB:`UART_BAUD_LSB];
	assign parity_sel = uart_setup_q[`UART_PAR_MSB:`UART_PAR_LSB];
	assign resp_delay_ms = delays_q[7:0];
	assign query_delay_ms = delays_q[15:8];
	assign conv_rate = conv_rate_q;
	assign large_filt = large_filt_q;
	assign small_filt = small_filt_q;
	assign chan_enable = chan_en_q;
	assign busy = state_q;

	// fixed conversion pace
	// one tick per conversion slot; the slot rate never depends on
	// how many channels are on, so per-channel rate scales freely
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tick_cnt_q <= 32'h0;
			tick_q <= 1'b0;
		end
		else if (tick_cnt_q == CONV_PERIOD - 1)
		begin
			tick_cnt_q <= 32'h0;
			tick_q <= 1'b1;
		end
		else
		begin
			tick_cnt_q <= tick_cnt_q + 32'h1;
			tick_q <= 1'b0;
		end
	end

	assign seq_next = next_chan(cur_chan_q, chan_en_q);

	// scan sequencer; a tick arriving mid-conversion is dropped
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= S_IDLE;
			cur_chan_q <= 3'h6;
			conv_start <= 1'b0;
			conv_chan <= 3'h0;
			conv_type <= `TYPE_J;
		end
		else
		begin
			conv_start <= 1'b0;
			case (state_q)
				S_IDLE:
				begin
					if (tick_q && (chan_en_q != 7'h0))
					begin
						cur_chan_q <= seq_next;
						conv_chan <= seq_next;
						conv_type <= type_q[seq_next];
						conv_start <= 1'b1;
						state_q <= S_CONV;
					end
				end
				S_CONV:
				begin
					if (conv_done)
						state_q <= S_IDLE;
				end
				default:
					state_q <= S_IDLE;
			endcase
		end
	end

	// result capture and conversion bookkeeping
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			conv_cnt_q <= 8'h00;
			last_chan_q <= 3'h0;
			for (k = 0; k < `NUM_CHAN; k = k + 1)
				data_q[k] <= `RST_DATA;
		end
		else if (state_q == S_CONV && conv_done)
		begin
			data_q[cur_chan_q] <= conv_result;
			conv_cnt_q <= conv_cnt_q + 8'h01;
			last_chan_q <= cur_chan_q;
		end
	end

	// settings storage, written from the register port
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			slave_addr_q <= `RST_SLAVE_ADDR;
			uart_setup_q <= `RST_UART_SETUP;
			delays_q <= `RST_DELAYS;
			chan_en_q <= `RST_CHAN_ENABLE;
			conv_rate_q <= `RST_CONV_RATE;
			large_filt_q <= `RST_FILTER;
			small_filt_q <= `RST_FILTER;
			for (m = 0; m < `NUM_CHAN; m = m + 1)
				type_q[m] <= `RST_TYPE;
		end
		else if (reg_wr)
		begin
			case (reg_addr)
				`REG_SLAVE_ADDR:
					slave_addr_q <= reg_wdata[7:0];
				`REG_UART_SETUP:
					uart_setup_q <= {9'h0, reg_wdata[6:0]};
				`REG_DELAYS:
					delays_q <= reg_wdata;
				`REG_CHAN_ENABLE:
					chan_en_q <= reg_wdata[6:0];
				`REG_CONV_RATE:
					conv_rate_q <= reg_wdata;
				`REG_LARGE_FILT:
					large_filt_q <= reg_wdata;
				`REG_SMALL_FILT:
					small_filt_q <= reg_wdata;
				default:
				begin
					if (in_chan_block(reg_addr, `REG_TYPE_BASE))
						type_q[wr_idx] <= reg_wdata[2:0];
				end
			endcase
		end
	end

	// register read path
	// data stand only in the cycle after the strobe; unmapped reads zero
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			reg_rdata <= 16'h0000;
		else if (!reg_rd)
			reg_rdata <= 16'h0000;
		else
		begin
			case (reg_addr)
				`REG_SLAVE_ADDR:
					reg_rdata <= {8'h00, slave_addr_q};
				`REG_UART_SETUP:
					reg_rdata <= uart_setup_q;
				`REG_DELAYS:
					reg_rdata <= delays_q;
				`REG_CHAN_ENABLE:
					reg_rdata <= {9'h000, chan_en_q};
				`REG_CONV_RATE:
					reg_rdata <= conv_rate_q;
				`REG_LARGE_FILT:
					reg_rdata <= large_filt_q;
				`REG_SMALL_FILT:
					reg_rdata <= small_filt_q;
				`REG_VERSION:
					reg_rdata <= VERSION_CODE;
				`REG_CONV_STATUS:
					reg_rdata <= {5'h00, last_chan_q, conv_cnt_q};
				default:
				begin
					if (in_chan_block(reg_addr, `REG_TYPE_BASE))
						reg_rdata <= {13'h0000, type_q[wr_idx]};
					else if (in_chan_block(reg_addr, `REG_DATA_BASE))
						reg_rdata <= data_q[rd_idx];
					else
						reg_rdata <= 16'h0000;
				end
			endcase
		end
	end

endmodule // tc_scan_ctrl

/* tc_scan_chk_assertions.sv */
`timescale 1ns/1ps
module tc_scan_chk #(
	parameter CONV_PERIOD = 20
)(
	// clock and reset
	input wire core_clk,
	input wire rst_n,
	// register port
	input wire reg_rd,
	input wire [15:0] reg_rdata,
	// converter side
	input wire conv_start,
	input wire [2:0] conv_chan,
	input wire [2:0] conv_type,
	input wire conv_done,
	input wire busy,
	// settings
	input wire [6:0] chan_enable,
	input wire [7:0] slave_addr,
	input wire [4:0] baud_sel,
	input wire [1:0] parity_sel,
	input wire [7:0] resp_delay_ms,
	input wire [7:0] query_delay_ms
);
	int gap_q;
	logic [6:0] en_q;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// gap since last start; reset value lets the first start pass
	always @(posedge core_clk or negedge rst_n)
		if (!rst_n)
		begin
			gap_q <= CONV_PERIOD;
			en_q <= 7'h7f;
		end
		else
		begin
			gap_q <= conv_start ? 1 : gap_q + 1;
			en_q <= chan_enable;
		end
	property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 16'h0000; endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data not idle");
	property p_start; conv_start |-> $rose(busy); endproperty
	a_start: assert property (p_start)
		else $error("start while busy");
	property p_done; busy && conv_done |=> !busy; endproperty
	a_done: assert property (p_done)
		else $error("busy after done");
	property p_en; conv_start |-> en_q[conv_chan]; endproperty
	a_en: assert property (p_en)
		else $error("disabled channel started");
	property p_gap; conv_start |-> gap_q >= CONV_PERIOD; endproperty
	a_gap: assert property (p_gap)
		else $error("conversions too close");
	property p_chan; !conv_start |-> $stable(conv_chan); endproperty
	a_chan: assert property (p_chan)
		else $error("channel moved");
	property p_type; !conv_start |-> $stable(conv_type); endproperty
	a_type: assert property (p_type)
		else $error("type moved");
	property p_dflt;
		$rose(rst_n) |-> slave_addr == 8'h01 && baud_sel == 5'h05 &&
			parity_sel == 2'h3 && resp_delay_ms == 8'h03 &&
			query_delay_ms == 8'h00;
	endproperty
	a_dflt: assert property (p_dflt)
		else $error("bad serial defaults");
	c_start: cover property (conv_start);
	c_done: cover property (busy && conv_done);
	c_rd: cover property (reg_rd);
endmodule // tc_scan_chk

bind tc_scan_ctrl tc_scan_chk #(.CONV_PERIOD(CONV_PERIOD)) chk_u (.core_clk,
	.rst_n, .reg_rd, .reg_rdata, .conv_start, .conv_chan, .conv_type,
	.conv_done, .busy, .chan_enable, .slave_addr, .baud_sel, .parity_sel,
	.resp_delay_ms, .query_delay_ms);

/* tc_conv_model.sv */
`timescale 1ns/1ps
module tc_conv_model (
	// clock and reset
	input wire core_clk,
	input wire rst_n,
	// converter handshake
	input wire conv_start,
	input wire [2:0] conv_chan,
	input wire [3:0] lat,
	output logic conv_done,
	output logic [15:0] conv_result
);
	logic [3:0] n;
	logic [2:0] ch;
	// sixteen-bit result
	// result toggles outside done so a stale value never looks valid
	always @(posedge core_clk or negedge rst_n)
		if (!rst_n)
		begin
			n <= 4'h0;
			ch <= 3'h0;
			conv_done <= 1'b0;
			conv_result <= 16'h0000;
		end
		else
		begin
			conv_done <= n == 4'h1;
			conv_result <= n == 4'h1 ? {ch, 13'h1234} : ~conv_result;
			if (conv_start)
			begin
				n <= lat;
				ch <= conv_chan;
			end
			else if (n != 4'h0)
				n <= n - 4'h1;
		end
endmodule // tc_conv_model

/* tc_scan_ctrl_bench.sv */
`timescale 1ns/1ps
module tc_scan_ctrl_bench;
	logic core_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, typed = 0;
	logic [7:0] reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic [3:0] lat = 4'hf;
	logic [2:0] lastc = 3'h0, prevc = 3'h6;
	logic [6:0] en_d = 7'h7f, seen = 7'h00;
	logic [15:0] dv [7] = '{16'h1, 16'h65, 16'h3, 16'h7f, 16'h3c, 0, 0};
	logic [15:0] wv [7] = '{16'h22, 16'hffff, 16'h3f30, 0, 16'h32, 16'h9, 1};
	wire [15:0] reg_rdata, conv_result;
	wire [15:0] conv_rate, large_filt, small_filt;
	wire [7:0] slave_addr, resp_delay_ms, query_delay_ms;
	wire [4:0] baud_sel;
	wire [1:0] parity_sel;
	wire [6:0] chan_enable;
	wire [2:0] conv_chan, conv_type;
	wire conv_start, conv_done, busy;
	int mismatches, num_checks, ndone, nstart, i;
	// short period keeps the run brief
	tc_scan_ctrl #(.CONV_PERIOD(20)) dut_u (.core_clk, .rst_n, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .conv_start, .conv_chan,
		.conv_type, .conv_done, .conv_result, .slave_addr, .baud_sel,
		.parity_sel, .resp_delay_ms, .query_delay_ms, .conv_rate,
		.large_filt, .small_filt, .chan_enable, .busy);
	tc_conv_model cv_u (.core_clk, .rst_n, .conv_start, .conv_chan, .lat,
		.conv_done, .conv_result);
	initial
		forever #5 core_clk = ~core_clk;
	task chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_wr <= 1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 0;
	endtask
	task rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge core_clk);
		reg_rd <= 1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 0;
		@(negedge core_clk);
		chk(reg_rdata, e);
	endtask
	// bounded wait for a fresh done; returns after its capture edge
	task wdone;
		int j;
		j = 0;
		@(negedge core_clk);
		while (!conv_done && j < 400)
		begin
			@(negedge core_clk);
			j++;
		end
		chk(16'(conv_done), 16'h1);
		@(negedge core_clk);
	endtask
	function logic [2:0] nxt(input logic [2:0] p, input logic [6:0] e);
		nxt = p;
		for (int k = 7; k > 0; k--)
			if (e[(p + k) % 7])
				nxt = 3'((p + k) % 7);
	endfunction
	// track expected scan order and completions
	always @(posedge core_clk)
		if (rst_n)
		begin
			if (conv_start)
			begin
				nstart++;
				prevc = nxt(prevc, en_d);
				chk(16'(conv_chan), 16'(prevc));
				chk(16'(conv_type), typed ? 16'(conv_chan + 3'h1) : 0);
			end
			if (conv_done && busy)
			begin
				ndone++;
				lastc = conv_chan;
				seen[conv_chan] = 1'b1;
			end
			en_d = chan_enable;
		end
	task give_verdict;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial
	begin
		#200000;
		mismatches++;
		give_verdict;
	end
	initial
	begin
		repeat (16) @(posedge core_clk);
		rst_n <= 1;
		for (i = 0; i < 7; i++)
			rd(8'(8'h30 + i), 16'h8000);
		rd(8'h2f, 16'h0000);
		for (i = 0; i < 14; i++)
			rd(8'(i), i < 7 ? dv[i] : 0);
		$display("defaults done");
		for (i = 0; i < 7; i++)
		begin
			wr(8'(i), wv[i]);
			rd(8'(i), i == 1 ? 16'h007f : wv[i]);
		end
		chk(16'(slave_addr), 16'h0022);
		chk(16'({parity_sel, baud_sel}), 16'h007f);
		chk({query_delay_ms, resp_delay_ms}, 16'h3f30);
		chk(conv_rate, 16'h0032);
		chk(large_filt, 16'h0009);
		chk(small_filt, 16'h0001);
		chk(16'(chan_enable), 16'h0000);
		for (i = 0; i < 7; i++)
			wr(8'(7 + i), 16'(i + 1));
		rd(8'h0d, 16'h0007);
		wr(8'h30, 16'h1111);
		rd(8'h30, 16'h1234);
		rd(8'h1f, 16'h0000);
		rd(8'h20, 16'h0001);
		rd(8'h2f, {5'h0, lastc, 8'(ndone)});
		$display("settings done");
		lat <= 4'h2;
		typed = 1;
		wr(8'h03, 16'h0055);
		repeat (8) wdone;
		rd(8'h2f, {5'h0, lastc, 8'(ndone)});
		for (i = 0; i < 7; i++)
			rd(8'(8'h30 + i), seen[i] ? {3'(i), 13'h1234} : 16'h8000);
		chk(16'({seen[5], seen[3]}), 16'h0000);
		lat <= 4'hf;
		wr(8'h03, 16'h007f);
		repeat (260) wdone;
		rd(8'h2f, {5'h0, lastc, 8'(ndone)});
		wr(8'h03, 16'h0008);
		repeat (3) wdone;
		rd(8'h2f, {5'h0, 3'h3, 8'(ndone)});
		$display("scan done");
		wr(8'h03, 16'h0000);
		repeat (30) @(posedge core_clk);
		i = nstart;
		repeat (60) @(posedge core_clk);
		chk(16'(nstart), 16'(i));
		$display("idle done");
		give_verdict;
	end
endmodule // tc_scan_ctrl_bench
